// File: rtl/ptdc_defs.vh
// constants for the self-test disable control block
`ifndef PTDC_DEFS_VH
`define PTDC_DEFS_VH
// ----------------------------------------------------------------
// register map (word addresses on the plain port)
// ----------------------------------------------------------------
`define PTDC_ADDR_W 4
`define PTDC_A_DIG 4'h0
`define PTDC_A_ANA 4'h1
`define PTDC_A_CTRL 4'h2
`define PTDC_A_STAT 4'h3
`define PTDC_A_ENDIG 4'h4
`define PTDC_A_ENANA 4'h5
// ----------------------------------------------------------------
// digital word fields
// ----------------------------------------------------------------
`define PTDC_DIG_W 7
`define PTDC_DIG_RST 7'h02
`define PTDC_D_MASTER 0
`define PTDC_D_BIST 1
`define PTDC_D_UNLOCK 2
`define PTDC_D_LOSA 3
`define PTDC_D_LOSB 4
`define PTDC_D_WARN 5
`define PTDC_D_ERR 6
// ----------------------------------------------------------------
// analog word fields
// ----------------------------------------------------------------
`define PTDC_ANA_W 21
`define PTDC_ANA_RST 21'h000000
`define PTDC_A_MASTER 0
`define PTDC_A_OSC_EXCL 19
`define PTDC_A_BIAS_EXCL 20
`define PTDC_A_NTEST 18
// ----------------------------------------------------------------
// control and status bits
// ----------------------------------------------------------------
`define PTDC_C_TRIG 0
`define PTDC_S_BUSY 0
`define PTDC_S_DONE 1
`define PTDC_S_FAIL 2
`define PTDC_S_ANA_OK 3
`define PTDC_NSLOT 24
`define PTDC_SLOT_W 5
`define PTDC_SLOT_DIG 6
`endif

// File: rtl/ptdc_seq.v
// self-test sequencer: runs enabled slots one after another in fixed order
`timescale 1ns/1ps
module ptdc_seq (
  core_clk,
  rst_n,
  start,
  run_mask,
  test_done,
  test_pass,
  test_go,
  test_sel,
  busy,
  done,
  fail_mask
);
`include "ptdc_defs.vh"
  input wire core_clk;
  input wire rst_n;
  input wire start;
  input wire [`PTDC_NSLOT-1:0] run_mask;
  input wire test_done;
  input wire test_pass;
  output reg test_go;
  output reg [`PTDC_SLOT_W-1:0] test_sel;
  output wire busy;
  output reg done;
  output reg [`PTDC_NSLOT-1:0] fail_mask;

  localparam S_IDLE = 3'b001;
  localparam S_PICK = 3'b010;
  localparam S_WAIT = 3'b100;
  reg [2:0] st_q;
  reg [`PTDC_NSLOT-1:0] mask_q;
  reg [`PTDC_SLOT_W-1:0] idx_q;

  assign busy = ~st_q[0];

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= S_IDLE;
      mask_q <= {`PTDC_NSLOT{1'b0}};
      idx_q <= {`PTDC_SLOT_W{1'b0}};
      test_go <= 1'b0;
      test_sel <= {`PTDC_SLOT_W{1'b0}};
      done <= 1'b0;
      fail_mask <= {`PTDC_NSLOT{1'b0}};
    end else begin
      test_go <= 1'b0;
      done <= 1'b0;
      case (st_q)
        S_IDLE: begin
          if (start) begin
            // word sampled once, later writes do not disturb this run (see RULE17)
            mask_q <= run_mask;
            idx_q <= {`PTDC_SLOT_W{1'b0}};
            fail_mask <= {`PTDC_NSLOT{1'b0}};
            st_q <= S_PICK;
          end
        end
        S_PICK: begin
          if (idx_q == `PTDC_NSLOT) begin
            done <= 1'b1;
            st_q <= S_IDLE;
          end else if (mask_q[idx_q]) begin
            // skipped slots cost one cycle each (see RULE17)
            test_go <= 1'b1;
            test_sel <= idx_q;
            st_q <= S_WAIT;
          end else begin
            idx_q <= idx_q + 5'h01;
          end
        end
        S_WAIT: begin
          if (test_done) begin
            fail_mask[idx_q] <= ~test_pass;
            idx_q <= idx_q + 5'h01;
            st_q <= S_PICK;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
endmodule

// File: rtl/ptdc_top.v
// self-test disable words, trigger and analog status combine
// Operation
// RULE1 - digital bit 6 set skips the crystal ppm error test; resets clear.
// RULE2 - digital bit 5 set skips the crystal ppm warning test.
// RULE3 - digital bit 4 set skips crystal b signal loss test.
// RULE4 - digital bit 3 set skips crystal a signal loss test.
// RULE5 - digital bit 2 set skips the pll unlock test.
// RULE6 - digital bit 1 resets to one; while one, no logic bist at startup.
// RULE7 - nonvolatile defaults need a matching bist signature when bist enabled.
// RULE8 - digital bit 0 set blocks every digital test; the startup bist (bist_go) here follows bit 1 only and ignores bit 0.
// RULE9 - analog bit 20 drops bias calibration result from analog status.
// RULE10 - analog bit 19 drops oscillator calibration result from analog status.
// RULE11 - analog bits 18,17,16 skip low-fault, in-range, high-fault checks.
// RULE12 - analog bits 15,14 skip crystal b and a reference regulator tests.
// RULE13 - analog bits 13,12,11 skip charge-pump, phase-detector, oscillator regs.
// RULE14 - analog bits 10 to 4 skip the seven output divider regulator tests.
// RULE15 - analog bits 3,2,1 skip fractional, pll divider, core supply regs.
// RULE16 - analog bit 0 set blocks every analog regulator test.
// RULE17 - each trigger samples both words once, runs enabled tests in fixed order.
//
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module ptdc_top (
  core_clk,
  rst_n,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  startup_done,
  test_done,
  test_pass,
  bias_cal_ok,
  osc_cal_ok,
  test_go,
  test_sel,
  bist_go,
  selftest_busy
);
`include "ptdc_defs.vh"
  input wire core_clk;
  input wire rst_n;
  input wire [`PTDC_ADDR_W-1:0] reg_addr;
  input wire [31:0] reg_wdata;
  input wire reg_wr;
  input wire reg_rd;
  output reg [31:0] reg_rdata;
  input wire startup_done;
  input wire test_done;
  input wire test_pass;
  input wire bias_cal_ok;
  input wire osc_cal_ok;
  output wire test_go;
  output wire [`PTDC_SLOT_W-1:0] test_sel;
  output reg bist_go;
  output wire selftest_busy;

  // ----------------------------------------------------------------
  // configuration words
  // ----------------------------------------------------------------
  reg [`PTDC_DIG_W-1:0] dig_q;
  reg [`PTDC_ANA_W-1:0] ana_q;
  reg trig_q;
  reg done_q;
  reg fail_q;
  reg bist_armed_q;
  // external calibration flags come from other logic, synchronise anyway
  reg [1:0] bias_s_q;
  reg [1:0] osc_s_q;
  reg [1:0] boot_s_q;
  wire seq_busy;
  wire seq_done;
  wire [`PTDC_NSLOT-1:0] fails;
  wire [`PTDC_NSLOT-1:0] run_mask;
  wire ana_ok;

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dig_q <= `PTDC_DIG_RST; // see RULE6
      ana_q <= `PTDC_ANA_RST;
      trig_q <= 1'b0;
    end else begin
      trig_q <= 1'b0;
      if (reg_wr) begin
        case (reg_addr)
          `PTDC_A_DIG: dig_q <= reg_wdata[`PTDC_DIG_W-1:0];
          `PTDC_A_ANA: ana_q <= reg_wdata[`PTDC_ANA_W-1:0];
          `PTDC_A_CTRL: trig_q <= reg_wdata[`PTDC_C_TRIG];
          default: trig_q <= 1'b0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // run mask: slots 0-5 digital, 6-23 analog checks and regulators from bit 18 down to bit 1
  // ----------------------------------------------------------------
  wire dig_on = ~dig_q[`PTDC_D_MASTER]; // see RULE8
  wire ana_on = ~ana_q[`PTDC_A_MASTER]; // see RULE16
  assign run_mask[0] = dig_on & ~dig_q[`PTDC_D_ERR]; // see RULE1
  assign run_mask[1] = dig_on & ~dig_q[`PTDC_D_WARN]; // see RULE2
  assign run_mask[2] = dig_on & ~dig_q[`PTDC_D_LOSB]; // see RULE3
  assign run_mask[3] = dig_on & ~dig_q[`PTDC_D_LOSA]; // see RULE4
  assign run_mask[4] = dig_on & ~dig_q[`PTDC_D_UNLOCK]; // see RULE5
  // bist slot on trigger too, under the same master gate
  assign run_mask[5] = dig_on & ~dig_q[`PTDC_D_BIST]; // see RULE6
  genvar gi;
  generate
    for (gi = 0; gi < `PTDC_A_NTEST; gi = gi + 1) begin : g_ana
      // slot 6+i follows analog bit 18-i: bit 18 runs first (see RULE11)
      // (see RULE12) (see RULE13) (see RULE14) (see RULE15)
      assign run_mask[`PTDC_SLOT_DIG + gi] = ana_on & ~ana_q[`PTDC_A_NTEST - gi];
    end
  endgenerate

  ptdc_seq u_seq (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .start(trig_q),
    .run_mask(run_mask),
    .test_done(test_done),
    .test_pass(test_pass),
    .test_go(test_go),
    .test_sel(test_sel),
    .busy(seq_busy),
    .done(seq_done),
    .fail_mask(fails)
  );

  assign selftest_busy = seq_busy;

  // ----------------------------------------------------------------
  // analog status combine
  // ----------------------------------------------------------------
  assign ana_ok = ~(|fails[`PTDC_NSLOT-1:`PTDC_SLOT_DIG])
    & (ana_q[`PTDC_A_BIAS_EXCL] | bias_s_q[1]) // see RULE9
    & (ana_q[`PTDC_A_OSC_EXCL] | osc_s_q[1]); // see RULE10

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bias_s_q <= 2'h0;
      osc_s_q <= 2'h0;
      boot_s_q <= 2'h0;
      done_q <= 1'b0;
      fail_q <= 1'b0;
      bist_armed_q <= 1'b1;
      bist_go <= 1'b0;
    end else begin
      bias_s_q <= {bias_s_q[0], bias_cal_ok};
      osc_s_q <= {osc_s_q[0], osc_cal_ok};
      boot_s_q <= {boot_s_q[0], startup_done};
      bist_go <= 1'b0;
      // startup bist fires once; signature correctness is up to nvm defaults (see RULE7)
      if (bist_armed_q && boot_s_q[1]) begin
        bist_armed_q <= 1'b0;
        bist_go <= ~dig_q[`PTDC_D_BIST]; // see RULE6
      end
      // a finished run beats a trigger in the same cycle, so its status is never lost
      if (seq_done) begin
        done_q <= 1'b1;
        fail_q <= |fails;
      end else if (trig_q) begin
        done_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // read port, data one cycle after strobe
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h00000000;
    end else begin
      reg_rdata <= 32'h00000000;
      if (reg_rd) begin
        case (reg_addr)
          `PTDC_A_DIG: reg_rdata <= {25'h0000000, dig_q};
          `PTDC_A_ANA: reg_rdata <= {11'h000, ana_q};
          `PTDC_A_STAT: reg_rdata <= {28'h0000000, ana_ok & done_q, fail_q, done_q, seq_busy};
          `PTDC_A_ENDIG: reg_rdata <= {26'h0000000, run_mask[`PTDC_SLOT_DIG-1:0]};
          `PTDC_A_ENANA: reg_rdata <= {14'h0000, run_mask[`PTDC_NSLOT-1:`PTDC_SLOT_DIG]};
          default: reg_rdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

// File: verif/ptdc_top_props.sv
// port timing checker for the self-test disable control block
`timescale 1ns/1ps
`include "ptdc_defs.vh"
module ptdc_top_props (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [`PTDC_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic test_done,
  input wire logic test_go,
  input wire logic [`PTDC_SLOT_W-1:0] test_sel,
  input wire logic bist_go,
  input wire logic selftest_busy
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ----
  // assertions
  // ----
  chk_go_single: assert property (test_go |=> !test_go)
    else $error("test_go wider than one cycle");
  chk_go_busy: assert property (test_go |-> selftest_busy)
    else $error("test_go outside a run");
  chk_sel_range: assert property (test_go |-> test_sel < `PTDC_NSLOT)
    else $error("slot number out of range");
  chk_sel_hold: assert property (test_go |=> $stable(test_sel))
    else $error("slot number moved after start");
  chk_done_gap: assert property (test_done && selftest_busy |=> !test_go)
    else $error("next slot started too early");
  chk_bist_once: assert property (bist_go |=> !bist_go [*8])
    else $error("startup bist fired again");
  chk_trig_run: assert property (reg_wr && reg_addr == `PTDC_A_CTRL && reg_wdata[0]
    && !selftest_busy |-> ##[1:4] selftest_busy)
    else $error("trigger did not start a run");
  // the analog word readback feeds the run mask the sequencer samples, so a stuck word shows here first
  chk_ana_back: assert property ((reg_wr && reg_addr == `PTDC_A_ANA) ##1
    (reg_rd && reg_addr == `PTDC_A_ANA) |=> reg_rdata == {11'h000, $past(reg_wdata[20:0], 2)})
    else $error("analog word readback wrong");
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h00000000)
    else $error("read data outside read cycle");
  cov_last_slot: cover property (test_go && test_sel == 5'h17);
  cov_bist: cover property (bist_go);
  cov_done: cover property (test_done && selftest_busy);
endmodule
bind ptdc_top ptdc_top_props u_props (.core_clk(core_clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .test_done(test_done), .test_go(test_go),
  .test_sel(test_sel), .bist_go(bist_go), .selftest_busy(selftest_busy));

// File: verif/tb_post_test_disable_control.sv
// self-checking bench for the self-test disable control block
`timescale 1ns/1ps
`include "ptdc_defs.vh"
module tb_post_test_disable_control;
  // ----
  // stimulus and tasks
  // ----
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, startup_done = 1'b0, test_done = 1'b0;
  logic test_pass = 1'b0, bias_cal_ok = 1'b1, osc_cal_ok = 1'b1;
  logic [31:0] reg_rdata;
  logic test_go, bist_go, selftest_busy;
  logic [4:0] test_sel;
  int mismatches = 0, compares = 0, nbist = 0, nb0 = 0;
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) if (bist_go === 1'b1) nbist <= nbist + 1;
  ptdc_top uut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .startup_done(startup_done), .test_done(test_done), .test_pass(test_pass),
    .bias_cal_ok(bias_cal_ok), .osc_cal_ok(osc_cal_ok), .test_go(test_go),
    .test_sel(test_sel), .bist_go(bist_go), .selftest_busy(selftest_busy));
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  function automatic logic en(input logic [6:0] dg, input logic [20:0] an, input int s);
    if (s < 6) en = !dg[0] && !dg[6-s];
    else en = !an[0] && !an[24-s];
  endfunction
  task automatic do_reset(input logic su);
    @(posedge core_clk);
    rst_n <= 1'b0;
    startup_done <= su;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
  endtask
  // wr leaves the strobe up so a following rd sits back to back
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    check("rdata", reg_rdata, e);
  endtask
  task automatic run(input logic [6:0] dg, input logic [20:0] an, input logic ps,
                     input logic bo, input logic oo);
    int k, p, n, na;
    logic ok;
    logic [31:0] msk;
    bias_cal_ok <= bo;
    osc_cal_ok <= oo;
    test_pass <= ps;
    wr(`PTDC_A_DIG, {25'h0, dg});
    wr(`PTDC_A_ANA, {11'h0, an});
    rd(`PTDC_A_ANA, {11'h0, an});
    msk = 32'h0;
    for (k = 0; k < 6; k++) msk[k] = en(dg, an, k);
    rd(`PTDC_A_ENDIG, msk);
    msk = 32'h0;
    for (k = 0; k < 18; k++) msk[k] = en(dg, an, k + 6);
    rd(`PTDC_A_ENANA, msk);
    wr(`PTDC_A_CTRL, 32'h1);
    p = 0;
    n = 0;
    na = 0;
    for (k = 0; k < 600; k++) begin
      @(posedge core_clk);
      reg_wr <= 1'b0;
      test_done <= test_go;
      if (test_go === 1'b1) begin
        while (p < 24 && !en(dg, an, p)) p++;
        check("slot", test_sel, p);
        na += (p > 5);
        p++;
        n++;
      end
      if (k > 8 && selftest_busy === 1'b0) break;
    end
    check("run end", k < 600, 1);
    if (k == 600) summarize;
    while (p < 24 && !en(dg, an, p)) p++;
    check("slots left", p, 24);
    ok = (ps || na == 0) && (bo || an[20]) && (oo || an[19]);
    rd(`PTDC_A_STAT, {28'h0, ok, !ps && n > 0, 2'b10});
  endtask
  initial begin
    do_reset(1'b1);
    repeat (10) @(posedge core_clk);
    check("bist off", nbist, 0);
    rd(`PTDC_A_DIG, 32'h2);
    rd(`PTDC_A_ANA, 32'h0);
    rd(4'hF, 32'h0);
    wr(`PTDC_A_ANA, 32'hFFFFFFFF);
    rd(`PTDC_A_ANA, 32'h001FFFFF);
    run(7'h00, 21'h000000, 1'b1, 1'b1, 1'b1);
    run(7'h55, 21'h015556, 1'b0, 1'b1, 1'b1);
    run(7'h2A, 21'h100001, 1'b1, 1'b0, 1'b1);
    run(7'h54, 21'h0AAAA8, 1'b1, 1'b1, 1'b0);
    run(7'h7E, 21'h07FFFE, 1'b1, 1'b1, 1'b0);
    // digital fail alone must not spoil the analog status
    run(7'h3E, 21'h000001, 1'b0, 1'b1, 1'b1);
    run(7'h01, 21'h000001, 1'b1, 1'b0, 1'b1);
    do_reset(1'b0);
    nb0 = nbist;
    // bench stands in for nvm defaults with bist on; signature taken as matching
    wr(`PTDC_A_DIG, 32'h0);
    rd(`PTDC_A_DIG, 32'h0);
    startup_done <= 1'b1;
    repeat (20) @(posedge core_clk);
    check("bist once", nbist - nb0, 1);
    summarize;
  end
endmodule
